//--- src/ces_pkg.sv
/*
 * Shared constants, types and structs of the exception sequencer.
 * Assumes a 32-bit CPU whose bus interface answers one word per request.
 */
package ces_pkg;
    localparam int XLEN = 32;
    // Vector numbers
    localparam logic [7:0] VEC_POR_PC = 8'h00;
    localparam logic [7:0] VEC_MR_PC = 8'h02;
    localparam logic [7:0] VEC_GEN_ILL = 8'h04;
    localparam logic [7:0] VEC_SLOT_ILL = 8'h06;
    localparam logic [7:0] VEC_CPU_AE = 8'h09;
    localparam logic [7:0] VEC_DMA_AE = 8'h0a;
    localparam logic [7:0] VEC_NMI = 8'h0b;
    localparam logic [7:0] VEC_UBRK = 8'h0c;
    localparam logic [7:0] VEC_DBG_INT = 8'h0d;
    localparam logic [7:0] VEC_TRAP_LO = 8'h20;
    localparam logic [7:0] VEC_TRAP_HI = 8'h3f;
    localparam logic [7:0] VEC_IRQ_LO = 8'h40;
    localparam logic [7:0] VEC_PERI_LO = 8'h80;
    localparam int VEC_SHIFT = 2;
    localparam int TRAP_FIELD_W = 5;
    // Status word and reset values
    localparam int IMASK_LSB = 4;
    localparam logic [3:0] IMASK_ALL = 4'hf;
    localparam logic [4:0] NMI_LEVEL = 5'h10;
    localparam logic [31:0] VBR_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam int MR_MIN_LOW_CYC = 20;

    typedef enum logic [1:0] {RK_POWER, RK_MANUAL, RK_DEBUG} ces_rkind_t;
    typedef enum logic [1:0] {CL_ADDR, CL_IRQ, CL_INSTR} ces_cls_t;

    typedef struct packed {
        logic [31:0] sr;
        logic [31:0] sp;
        logic [31:0] vector_base;
        logic [31:0] ret_pc;
    } ces_ctx_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic we;
    } ces_bus_t;

    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] vector_base;
        logic [31:0] sr;
        logic ld_vbr;
    } ces_load_t;
endpackage

//--- src/ces_vec_addr.sv
/*
 * Vector table address computation.
 * Assumes the caller says whether the vector base applies.
 */
`timescale 1ns/1ps
module ces_vec_addr import ces_pkg::*; #(
    parameter int XW = XLEN // Address width
) (
    input wire logic use_base, // Add vector base
    input wire logic [XW-1:0] vector_base, // Vector base
    input wire logic [7:0] vec_num, // Vector number
    output logic [XW-1:0] addr // Table address
);
    // The table spans 1 KiB, so narrower addresses cannot reach it
    if (XW < 10) begin : g_bad_xw
        $error("ces_vec_addr: XW too small");
    end

    logic [XW-1:0] offs;
    assign offs = XW'(vec_num) << VEC_SHIFT;
    assign addr = use_base ? vector_base + offs : offs;
endmodule // ces_vec_addr

//--- src/ces_seq.sv
/*
 * Exception sequencer: reset sequencing, exception ranking, stack push
 * and vector fetch for the CPU core.
 * Assumes inputs synchronous to sys_clk, a bus interface that answers a
 * held request with a one-cycle mem_ack, and a pipeline that applies
 * load_o when load_valid pulses.
 */
`timescale 1ns/1ps
module ces_seq import ces_pkg::*; (
    input wire logic sys_clk, // Clock, 100 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic power_on_reset_n, // Power-on reset pin
    input wire logic manual_reset_n, // Manual reset pin
    input wire logic dbg_reset_req, // Debug interface reset pulse
    input wire logic bus_busy, // A bus cycle is in progress
    input wire logic dec_valid, // Instruction decoded this cycle
    input wire logic dec_undefined, // Decoded code is undefined
    input wire logic dec_pc_write, // Decoded code rewrites the PC
    input wire logic dec_in_slot, // Decoded code sits in a delay slot
    input wire logic exec_done, // Previous instruction finished
    input wire logic trap_exec, // Trap instruction executes
    input wire logic [7:0] trap_num, // Trap immediate
    input wire logic cpu_addr_err, // CPU address error pulse
    input wire logic dma_addr_err, // DMA address error pulse
    input wire logic irq_req, // Interrupt request level
    input wire logic [4:0] irq_level, // Request priority 0..16
    input wire logic irq_ext, // Request is an external line
    input wire logic [2:0] irq_line, // External line number
    input wire logic [7:0] irq_vec, // Vector for internal sources
    input wire ces_ctx_t ctx, // CPU context
    input wire logic mem_ack, // Bus answer
    input wire logic [31:0] mem_rdata, // Bus read data
    output logic mem_req, // Bus request
    output ces_bus_t mem_o, // Bus address, data, write
    output logic cpu_hold, // CPU held in reset state
    output logic periph_init, // Peripherals initialized
    output logic mem_retain, // Keep memory retention running
    output logic exc_take, // Exception accepted, flush pipe
    output logic irq_ack, // Interrupt accepted
    output logic load_valid, // Apply load_o this cycle
    output ces_load_t load_o // New CPU state
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_HOLD, ST_RPC, ST_RSP, ST_PSR, ST_PPC, ST_VEC, ST_LOAD
    } ces_state_t;

    ces_state_t state_q, state_d;
    ces_rkind_t rkind_q;
    ces_cls_t cls_q, cls_d;
    logic por_prev_q, mr_prev_q, go_q, det_q, ae_cpu_q, ae_dma_q;
    logic [7:0] vec_q, vec_d, rvec;
    logic [4:0] lvl_q;
    logic [31:0] sp_q, sr_q, retpc_q, vbr_q, pcf_q;
    logic por_low, por_rise, mr_rise, own_bus, irq_ok, async_go, take;
    logic ill_gen, ill_slot, bus_st, use_vbr;
    logic [31:0] sp_src, sr_src, vaddr;
    logic [7:0] vsel;
    ces_bus_t bus_d;
    ces_load_t load_d;

    assign por_low = ~power_on_reset_n | dbg_reset_req;
    assign por_rise = power_on_reset_n & ~por_prev_q;
    assign mr_rise = manual_reset_n & ~mr_prev_q;
    assign bus_st = state_q inside {ST_RPC, ST_RSP, ST_PSR, ST_PPC, ST_VEC};
    assign own_bus = bus_st & ~mem_ack;
    assign mem_req = bus_st & ~por_low;

    // Pins sampled each edge; reset to the idle high level so no false rise follows
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            por_prev_q <= 1'b1;
            mr_prev_q <= 1'b1;
        end else begin
            por_prev_q <= power_on_reset_n;
            mr_prev_q <= manual_reset_n;
        end
    end

    // Release seen; the set wins over the clear on leaving hold
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            go_q <= 1'b1;
        end else if (por_rise || mr_rise || dbg_reset_req) begin
            go_q <= 1'b1;
        end else if (state_q == ST_HOLD && state_d == ST_RPC) begin
            go_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rkind_q <= RK_POWER;
        end else if (dbg_reset_req && power_on_reset_n) begin
            rkind_q <= RK_DEBUG;
        end else if (!power_on_reset_n) begin
            rkind_q <= RK_POWER;
        end else if (!manual_reset_n && state_d == ST_HOLD && state_q != ST_HOLD) begin
            rkind_q <= RK_MANUAL;
        end
    end

    // Exception sources
    assign ill_gen = dec_valid & dec_undefined & ~dec_in_slot;
    assign ill_slot = dec_valid & dec_in_slot & (dec_undefined | dec_pc_write);
    assign irq_ok = irq_req & ((irq_level == NMI_LEVEL) |
                    (irq_level > {1'b0, ctx.sr[IMASK_LSB +: 4]}));
    assign async_go = det_q & exec_done;

    // Address errors stay pending until taken or a reset hold; a new error wins over the take
    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_q == ST_HOLD) begin
            ae_cpu_q <= 1'b0;
        end else if (cpu_addr_err) begin
            ae_cpu_q <= 1'b1;
        end else if (take && cls_d == CL_ADDR && vec_d == VEC_CPU_AE) begin
            ae_cpu_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_q == ST_HOLD) begin
            ae_dma_q <= 1'b0;
        end else if (dma_addr_err) begin
            ae_dma_q <= 1'b1;
        end else if (take && cls_d == CL_ADDR && vec_d == VEC_DMA_AE) begin
            ae_dma_q <= 1'b0;
        end
    end

    // Detection happens at decode, the start waits for exec_done
    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_q == ST_HOLD) begin
            det_q <= 1'b0;
        end else if (dec_valid && (ae_cpu_q || ae_dma_q || irq_ok)) begin
            det_q <= 1'b1;
        end else if (take && cls_d != CL_INSTR) begin
            det_q <= 1'b0;
        end
    end

    // Ranking within the idle state; resets override in the FSM
    always_comb begin
        cls_d = CL_INSTR;
        vec_d = VEC_GEN_ILL;
        take = 1'b0;
        if (state_q == ST_IDLE && !por_low && manual_reset_n) begin
            if (async_go && (ae_cpu_q || ae_dma_q)) begin
                take = 1'b1;
                cls_d = CL_ADDR;
                vec_d = ae_cpu_q ? VEC_CPU_AE : VEC_DMA_AE;
            end else if (async_go && irq_ok) begin
                take = 1'b1;
                cls_d = CL_IRQ;
                vec_d = irq_ext ? (VEC_IRQ_LO | {5'h00, irq_line}) : irq_vec;
            end else if (trap_exec) begin
                take = 1'b1;
                vec_d = VEC_TRAP_LO | {3'b000, trap_num[TRAP_FIELD_W-1:0]};
            end else if (ill_slot) begin
                take = 1'b1;
                vec_d = VEC_SLOT_ILL;
            end else if (ill_gen) begin
                take = 1'b1;
                vec_d = VEC_GEN_ILL;
            end
        end
    end

    assign exc_take = take;
    assign irq_ack = take & (cls_d == CL_IRQ);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cls_q <= CL_INSTR;
            vec_q <= VEC_GEN_ILL;
            lvl_q <= 5'h00;
            sp_q <= 32'h0000_0000;
            sr_q <= 32'h0000_0000;
            retpc_q <= 32'h0000_0000;
            vbr_q <= VBR_RESET;
        end else if (take) begin
            cls_q <= cls_d;
            vec_q <= vec_d;
            lvl_q <= irq_level;
            sp_q <= ctx.sp;
            sr_q <= ctx.sr;
            retpc_q <= ctx.ret_pc;
            vbr_q <= ctx.vector_base;
        end
    end

    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_PSR;
                end
            end
            ST_HOLD: begin
                if (go_q && power_on_reset_n && manual_reset_n) begin
                    state_d = ST_RPC;
                end
            end
            ST_RPC: begin
                if (mem_ack) begin
                    state_d = ST_RSP;
                end
            end
            ST_RSP: begin
                if (mem_ack) begin
                    state_d = ST_LOAD;
                end
            end
            ST_PSR: begin
                if (mem_ack) begin
                    state_d = ST_PPC;
                end
            end
            ST_PPC: begin
                if (mem_ack) begin
                    state_d = ST_VEC;
                end
            end
            ST_VEC: begin
                if (mem_ack) begin
                    state_d = ST_LOAD;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (por_low) begin
            state_d = ST_HOLD;
        end else if (!manual_reset_n && !own_bus && !bus_busy) begin
            state_d = ST_HOLD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q <= ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Bus request words
    assign rvec = (rkind_q == RK_MANUAL) ? VEC_MR_PC : VEC_POR_PC;
    assign use_vbr = (state_d == ST_VEC);
    assign vsel = use_vbr ? vec_q : ((state_d == ST_RSP) ? rvec + 8'h01 : rvec);
    assign sp_src = (state_q == ST_IDLE) ? ctx.sp : sp_q;
    assign sr_src = (state_q == ST_IDLE) ? ctx.sr : sr_q;

    ces_vec_addr #(
        .XW(XLEN)
    ) u_vec (
        .use_base(use_vbr),
        .vector_base(vbr_q),
        .vec_num(vsel),
        .addr(vaddr)
    );

    always_comb begin
        bus_d = '0;
        case (state_d)
            ST_PSR: begin
                bus_d.addr = sp_src - WORD_BYTES;
                bus_d.wdata = sr_src;
                bus_d.we = 1'b1;
            end
            ST_PPC: begin
                bus_d.addr = sp_q - (WORD_BYTES << 1);
                bus_d.wdata = retpc_q;
                bus_d.we = 1'b1;
            end
            default: begin
                bus_d.addr = vaddr;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mem_o <= '0;
        end else begin
            mem_o <= bus_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pcf_q <= 32'h0000_0000;
        end else if (state_q == ST_RPC && mem_ack) begin
            pcf_q <= mem_rdata;
        end
    end

    // New CPU state, built on the last bus answer
    always_comb begin
        load_d = load_o;
        if (state_q == ST_RSP) begin
            load_d.pc = pcf_q;
            load_d.sp = mem_rdata;
            load_d.vector_base = VBR_RESET;
            load_d.sr = ctx.sr;
            load_d.sr[IMASK_LSB +: 4] = IMASK_ALL;
            load_d.ld_vbr = 1'b1;
        end else begin
            load_d.pc = mem_rdata;
            load_d.sp = sp_q - (WORD_BYTES << 1);
            load_d.vector_base = vbr_q;
            load_d.sr = sr_q;
            load_d.ld_vbr = 1'b0;
            if (cls_q == CL_IRQ) begin
                load_d.sr[IMASK_LSB +: 4] = (lvl_q == NMI_LEVEL) ? IMASK_ALL : lvl_q[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            load_o <= '0;
        end else if (state_d == ST_LOAD && state_q != ST_LOAD) begin
            load_o <= load_d;
        end
    end

    assign load_valid = (state_q == ST_LOAD);
    assign cpu_hold = (state_q == ST_HOLD);
    assign periph_init = cpu_hold & (rkind_q == RK_POWER);
    // Refresh and similar retention keep going through a manual reset
    assign mem_retain = ~(cpu_hold & (rkind_q == RK_POWER));

    sequence s_rst_fetch;
        state_q == ST_RPC && mem_ack ##1 state_q == ST_RSP;
    endsequence

    sequence s_push;
        state_q == ST_PSR && mem_ack ##1 state_q == ST_PPC && mem_o.we;
    endsequence

    AST_POR_ABORT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !power_on_reset_n |-> !mem_req && !exc_take ##1 state_q == ST_HOLD)
        else $error("power-on reset did not abort at once");

    AST_NO_START_LOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_q == ST_HOLD && (!power_on_reset_n || !manual_reset_n) |=> state_q == ST_HOLD)
        else $error("reset sequence started while pin low");

    AST_RST_ORDER: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_rst_fetch |-> mem_o.addr == $past(mem_o.addr) + WORD_BYTES && !mem_o.we)
        else $error("reset fetch order wrong");

    AST_POR_VEC: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_q == ST_RPC && rkind_q != RK_MANUAL |-> mem_o.addr == 32'h0000_0000)
        else $error("power-on PC vector address wrong");

    AST_MR_VEC: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_q == ST_RSP && rkind_q == RK_MANUAL |-> mem_o.addr == 32'h0000_000c)
        else $error("manual SP vector address wrong");

    AST_MR_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !dbg_reset_req && power_on_reset_n && !manual_reset_n && own_bus && state_q != ST_HOLD
        |=> state_q != ST_HOLD)
        else $error("manual reset cut a bus cycle");

    AST_ASYNC_DONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        exc_take && cls_d != CL_INSTR |-> exec_done && det_q)
        else $error("async exception started early");

    AST_AE_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_b)
        exc_take && async_go && ae_cpu_q |=> cls_q == CL_ADDR && vec_q == VEC_CPU_AE)
        else $error("address error lost priority");

    AST_SLOT_VEC: assert property (@(posedge sys_clk) disable iff (!rst_b)
        exc_take && !async_go && !trap_exec && ill_slot |=> vec_q == VEC_SLOT_ILL)
        else $error("slot illegal vector wrong");

    AST_TRAP_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        exc_take && !async_go && trap_exec |=> vec_q >= VEC_TRAP_LO && vec_q <= VEC_TRAP_HI)
        else $error("trap vector out of range");

    AST_PUSH_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_push |-> mem_o.addr == sp_q - 32'h0000_0008 && mem_o.wdata == retpc_q)
        else $error("PC push address wrong");

    AST_VEC_BASE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_q == ST_VEC |-> mem_o.addr == vbr_q + {22'h000000, vec_q, 2'b00})
        else $error("handler vector address wrong");

    AST_RST_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(state_q) == ST_RSP && load_valid
        |-> load_o.vector_base == VBR_RESET && load_o.sr[IMASK_LSB +: 4] == 4'hf)
        else $error("reset load values wrong");

    AST_MASK_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(state_q) == ST_VEC && load_valid && cls_q != CL_IRQ |-> load_o.sr == sr_q)
        else $error("mask changed on non-interrupt");
endmodule // ces_seq

//--- bench/ces_mem_model.sv
/* Bus-side memory model of the exception sequencer.
   Assumes the sequencer holds each request until it sees mem_ack. */
`timescale 1ns/1ps
module ces_mem_model import ces_pkg::*; (
    input wire logic sys_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic mem_req, // Bus request
    input wire ces_bus_t mem_o, // Address, data, write
    input wire logic [3:0] lat, // Wait cycles before the answer
    output logic mem_ack, // One-cycle answer
    output logic [31:0] mem_rdata // Read data
);
    logic [3:0] wait_q;

    // Read data is valid only with the answer; it toggles otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !mem_req || mem_ack) begin
            wait_q <= 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= rst_b ? ~mem_rdata : 32'h0;
        end else if (wait_q >= lat) begin
            mem_ack <= 1'b1;
            mem_rdata <= 32'h5a00_0000 ^ mem_o.addr;
        end else begin
            wait_q <= wait_q + 4'h1;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // ces_mem_model

//--- bench/test_ces_seq.sv
/* Bench of the exception sequencer: scenario tasks drive the core side.
   Assumes ces_mem_model answers the bus side. */
`timescale 1ns/1ps
module test_ces_seq import ces_pkg::*;;
    localparam logic [31:0] SP0 = 32'h0000_4000;
    localparam logic [31:0] VB = 32'h0001_0000;
    localparam logic [31:0] PC0 = 32'h0000_2468;
    localparam logic [31:0] SR0 = 32'h0000_0030;
    logic sys_clk, rst_b, power_on_reset_n, manual_reset_n, dbg_reset_req, bus_busy;
    logic dec_valid, dec_undefined, dec_pc_write, dec_in_slot, exec_done, trap_exec;
    logic cpu_addr_err, dma_addr_err, irq_req, irq_ext, mem_ack, mem_req;
    logic cpu_hold, periph_init, mem_retain, exc_take, irq_ack, load_valid;
    logic [7:0] trap_num, irq_vec;
    logic [4:0] irq_level;
    logic [2:0] irq_line;
    logic [3:0] lat;
    logic [31:0] mem_rdata;
    ces_ctx_t ctx;
    ces_bus_t mem_o;
    ces_load_t load_o;
    int failures, samples_checked;

    ces_seq dut (.sys_clk, .rst_b, .power_on_reset_n, .manual_reset_n, .dbg_reset_req,
        .bus_busy, .dec_valid, .dec_undefined, .dec_pc_write, .dec_in_slot, .exec_done,
        .trap_exec, .trap_num, .cpu_addr_err, .dma_addr_err, .irq_req, .irq_level,
        .irq_ext, .irq_line, .irq_vec, .ctx, .mem_ack, .mem_rdata, .mem_req, .mem_o,
        .cpu_hold, .periph_init, .mem_retain, .exc_take, .irq_ack, .load_valid, .load_o);
    ces_mem_model mem (.sys_clk, .rst_b, .mem_req, .mem_o, .lat, .mem_ack, .mem_rdata);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus_step(input logic [31:0] a, input logic w, input logic [31:0] d);
        int i;
        for (i = 0; i < 60; i++) begin
            @(posedge sys_clk);
            if (mem_req === 1'b1 && mem_ack === 1'b1) break;
        end
        if (i == 60) begin
            chk("bus answer", 32'h1, 32'h0);
            stop_test();
        end
        chk("bus addr", a, mem_o.addr);
        chk("bus write", {31'h0, w}, {31'h0, mem_o.we});
        if (w) chk("bus wdata", d, mem_o.wdata);
    endtask

    task automatic wait_load(input logic [31:0] pc, input logic [31:0] sp,
            input logic [3:0] mask);
        int i;
        for (i = 0; i < 60 && load_valid !== 1'b1; i++) @(posedge sys_clk);
        if (i == 60) begin
            chk("load pulse", 32'h1, 32'h0);
            stop_test();
        end
        chk("load pc", pc, load_o.pc);
        chk("load sp", sp, load_o.sp);
        chk("load sr", {SR0[31:8], mask, SR0[3:0]}, load_o.sr);
    endtask

    // Reset fetch from base then base+4, then the fixed vector base and mask
    task automatic boot(input logic [31:0] base);
        bus_step(base, 1'b0, 32'h0);
        bus_step(base + 32'h4, 1'b0, 32'h0);
        wait_load(32'h5a00_0000 ^ base, 32'h5a00_0004 ^ base, IMASK_ALL);
        chk("load vbr", VBR_RESET, load_o.vector_base);
        chk("load ld_vbr", 32'h1, {31'h0, load_o.ld_vbr});
        $display("test boot at %h ended", base);
    endtask

    task automatic exc(input logic [7:0] vec, input logic [3:0] mask);
        logic [31:0] va;
        va = VB + {22'h0, vec, 2'b00};
        bus_step(SP0 - 32'h4, 1'b1, SR0);
        bus_step(SP0 - 32'h8, 1'b1, PC0);
        bus_step(va, 1'b0, 32'h0);
        wait_load(32'h5a00_0000 ^ va, SP0 - 32'h8, mask);
        chk("load ld_vbr", 32'h0, {31'h0, load_o.ld_vbr});
    endtask

    task automatic pulse_trap(input logic [7:0] n);
        @(posedge sys_clk);
        trap_exec <= 1'b1;
        trap_num <= n;
        #1 chk("trap take", 32'h1, {31'h0, exc_take});
        @(posedge sys_clk);
        trap_exec <= 1'b0;
    endtask

    task automatic t_trap();
        pulse_trap(8'h1f);
        exc(VEC_TRAP_HI, SR0[7:4]);
        $display("test trap ended");
    endtask

    task automatic t_irq(input logic [4:0] lv, input logic ext, input logic [2:0] line,
            input logic [7:0] vec, input logic [3:0] mask);
        @(posedge sys_clk);
        {irq_req, irq_level, irq_ext, irq_line, irq_vec} <= {1'b1, lv, ext, line, vec};
        {exec_done, dec_valid} <= 2'b01;
        @(posedge sys_clk);
        dec_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk("irq early", 32'h0, {31'h0, exc_take});
        @(posedge sys_clk);
        exec_done <= 1'b1;
        #1 chk("irq ack", 32'h1, {31'h0, irq_ack & exc_take});
        @(posedge sys_clk);
        irq_req <= 1'b0;
        exc(vec, mask);
        $display("test irq vector %h ended", vec);
    endtask

    // Errors detected first, then met by a trap: the address error must win
    task automatic t_prio();
        @(posedge sys_clk);
        {cpu_addr_err, dma_addr_err, exec_done, irq_req, irq_ext} <= 5'b11011;
        @(posedge sys_clk);
        {cpu_addr_err, dma_addr_err, dec_valid} <= 3'b001;
        @(posedge sys_clk);
        dec_valid <= 1'b0;
        @(posedge sys_clk);
        {trap_exec, trap_num, exec_done} <= {1'b1, 8'h01, 1'b1};
        #1 chk("prio take", 32'h2, {30'h0, exc_take, irq_ack});
        @(posedge sys_clk);
        trap_exec <= 1'b0;
        irq_req <= 1'b0;
        exc(VEC_CPU_AE, SR0[7:4]);
        @(posedge sys_clk);
        dec_valid <= 1'b1;
        @(posedge sys_clk);
        dec_valid <= 1'b0;
        exc(VEC_DMA_AE, SR0[7:4]);
        $display("test priority ended");
    endtask

    task automatic t_ill();
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            {dec_valid, dec_undefined, dec_pc_write, dec_in_slot} <= {1'b1, i < 2, i == 2, i > 0};
            @(posedge sys_clk);
            {dec_valid, dec_undefined, dec_pc_write, dec_in_slot} <= 4'h0;
            exc(i > 0 ? VEC_SLOT_ILL : VEC_GEN_ILL, SR0[7:4]);
        end
        $display("test illegal ended");
    endtask

    // Manual reset in mid bus cycle: the slow push must still complete
    task automatic t_manual();
        lat <= 4'h4;
        pulse_trap(8'h00);
        {manual_reset_n, bus_busy} <= 2'b01;
        bus_step(SP0 - 32'h4, 1'b1, SR0);
        #1 chk("busy keeps running", 32'h0, {31'h0, cpu_hold});
        @(posedge sys_clk);
        bus_busy <= 1'b0;
        bus_step(SP0 - 32'h8, 1'b1, PC0);
        repeat (3) @(posedge sys_clk);
        #1 chk("manual hold", 32'h3, {30'h0, cpu_hold, mem_retain});
        repeat (14) @(posedge sys_clk);
        manual_reset_n <= 1'b1;
        lat <= 4'h0;
        boot(32'h8);
        $display("test manual ended");
    endtask

    task automatic t_abort(input logic dbg);
        lat <= 4'h6;
        pulse_trap(8'h1f);
        repeat (2) @(posedge sys_clk);
        if (dbg) dbg_reset_req <= 1'b1;
        else power_on_reset_n <= 1'b0;
        #1 chk("abort req", 32'h0, {31'h0, mem_req});
        @(posedge sys_clk);
        {dbg_reset_req, power_on_reset_n, lat} <= {2'b01, 4'h0};
        #1 chk("abort hold", {30'h0, 1'b1, !dbg}, {30'h0, cpu_hold, periph_init});
        if (!dbg) chk("abort retain", 32'h0, {31'h0, mem_retain});
        boot(32'h0);
        $display("test abort ended");
    endtask

    initial begin
        rst_b = 1'b0;
        {power_on_reset_n, manual_reset_n, exec_done, lat} = 7'h70;
        {dbg_reset_req, bus_busy, dec_valid, dec_undefined, dec_pc_write} = 5'h0;
        {dec_in_slot, trap_exec, trap_num, cpu_addr_err, dma_addr_err} = 12'h0;
        {irq_req, irq_level, irq_ext, irq_line, irq_vec} = 18'h0;
        ctx = '{sr: SR0, sp: SP0, vector_base: VB, ret_pc: PC0};
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        boot(32'h0);
        t_trap();
        t_irq(5'd9, 1'b1, 3'd2, 8'h42, 4'h9);
        t_irq(NMI_LEVEL, 1'b0, 3'd0, VEC_NMI, IMASK_ALL);
        t_prio();
        t_ill();
        t_manual();
        t_abort(1'b0);
        t_abort(1'b1);
        stop_test();
    end
endmodule // test_ces_seq
